// ===== hdl/arl_rule_bank.sv
// arl_rule_bank: per-port protocol and tcp flag rule bytes behind the
// indirect control, offset and data byte registers.
// assumes a synchronous byte register port and one clock domain.
`timescale 1ns/1ps

// Functional notes
// RULE_01: indirect access reaches the ACL table only when table select is 010.
// RULE_02: control low nibble selects port 1 to 5; each port has own bytes.
// RULE_03: offset register picks the rule byte; 0x07 holds protocol and enable.
// RULE_04: selected rule byte is read and written through data register 0xA0.
// RULE_05: byte 7 bits 7..1 hold protocol value, read-write, reset zero.
// RULE_06: byte 7 bit 0 enables tcp flag compare, read-write, reset zero.
// RULE_07: byte 8 holds the eight-bit tcp flag mask, read-write, reset zero.
// RULE_08: with enable set, only mask-selected flag bits are compared.
module arl_rule_bank
(
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire arl_pkg::arl_bus_req_type  bus_req,
   output logic [7:0]                     bus_rdata,
   output logic                           bus_rvalid,
   input  wire arl_pkg::arl_pkt_type      pkt,
   output arl_pkg::arl_rule_cfg_type      rule_cfg,
   output arl_pkg::arl_match_type         match
);

   // ----------------------------------------------------------------
   // indirect selection
   // ----------------------------------------------------------------
   function automatic logic sel_ok(input logic [7:0] ctrl, input logic [7:0] offs);
      logic [3:0] port;
      port   = ctrl[arl_pkg::PORT_MSB:arl_pkg::PORT_LSB];
      sel_ok = (ctrl[arl_pkg::TSEL_MSB:arl_pkg::TSEL_LSB] == arl_pkg::TSEL_ACL)
               && (port >= arl_pkg::PORT_FIRST) && (port <= arl_pkg::PORT_LAST)
               && ((offs == arl_pkg::OFFS_PROTOCOL) || (offs == arl_pkg::OFFS_MASK)
                   || (offs == arl_pkg::OFFS_EXPECT));
   endfunction : sel_ok

   function automatic logic [2:0] port_index(input logic [7:0] ctrl);
      port_index = 3'(ctrl[arl_pkg::PORT_MSB:arl_pkg::PORT_LSB] - arl_pkg::PORT_FIRST);
   endfunction : port_index

   arl_pkg::arl_state_type state;
   arl_pkg::arl_state_type next_state;
   logic                   data_wr;
   logic                   data_rd;
   logic                   hit;
   logic [2:0]             idx;

   assign data_wr = bus_req.wr && (bus_req.addr == arl_pkg::ADDR_INDIRECT_DATA);
   assign data_rd = bus_req.rd && (bus_req.addr == arl_pkg::ADDR_INDIRECT_DATA);
   // RULE_01 table and port gate
   assign hit     = sel_ok(state.indirect_ctrl, state.indirect_offs);
   // RULE_02 per-port index
   assign idx     = port_index(state.indirect_ctrl);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state        = state;
      next_state.rvalid = bus_req.rd;
      next_state.rdata  = arl_pkg::RST_BYTE;
      if (bus_req.wr && (bus_req.addr == arl_pkg::ADDR_INDIRECT_CTRL))
         next_state.indirect_ctrl = bus_req.wdata;
      if (bus_req.wr && (bus_req.addr == arl_pkg::ADDR_INDIRECT_OFFS))
         next_state.indirect_offs = bus_req.wdata;
      // RULE_04 indirect data write
      if (data_wr && hit)
      begin
         // RULE_03 byte selection
         case (state.indirect_offs)
            arl_pkg::OFFS_PROTOCOL:
            begin
               // RULE_05 protocol value store
               next_state.cfg.ip_protocol_value[idx] =
                  bus_req.wdata[arl_pkg::PROTO_MSB:arl_pkg::PROTO_LSB];
               // RULE_06 enable store
               next_state.cfg.flag_compare_enable[idx] = bus_req.wdata[arl_pkg::FCE_BIT];
            end
            // RULE_07 mask store
            arl_pkg::OFFS_MASK:   next_state.cfg.tcp_flag_select_mask[idx] = bus_req.wdata;
            arl_pkg::OFFS_EXPECT: next_state.cfg.acl_rule_byte_nine[idx]   = bus_req.wdata;
            default:              next_state.cfg = state.cfg;
         endcase
      end
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            arl_pkg::ADDR_INDIRECT_CTRL: next_state.rdata = state.indirect_ctrl;
            arl_pkg::ADDR_INDIRECT_OFFS: next_state.rdata = state.indirect_offs;
            arl_pkg::ADDR_INDIRECT_DATA:
            begin
               // RULE_04 indirect data read
               if (hit && (state.indirect_offs == arl_pkg::OFFS_PROTOCOL))
                  next_state.rdata = {state.cfg.ip_protocol_value[idx],
                                      state.cfg.flag_compare_enable[idx]};
               else if (hit && (state.indirect_offs == arl_pkg::OFFS_MASK))
                  next_state.rdata = state.cfg.tcp_flag_select_mask[idx];
               else if (hit)
                  next_state.rdata = state.cfg.acl_rule_byte_nine[idx];
               else
                  next_state.rdata = arl_pkg::RST_BYTE;
            end
            default: next_state.rdata = arl_pkg::RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state                          <= '0;
         state.cfg.ip_protocol_value    <= {arl_pkg::NUM_PORTS{arl_pkg::RST_PROTOCOL}};
         state.cfg.flag_compare_enable  <= {arl_pkg::NUM_PORTS{arl_pkg::RST_FCE}};
         state.cfg.tcp_flag_select_mask <= {arl_pkg::NUM_PORTS{arl_pkg::RST_MASK}};
         state.cfg.acl_rule_byte_nine   <= {arl_pkg::NUM_PORTS{arl_pkg::RST_EXPECT}};
      end
      else
         state <= next_state;
   end

   assign bus_rdata  = state.rdata;
   assign bus_rvalid = state.rvalid;
   assign rule_cfg   = state.cfg;

   // ----------------------------------------------------------------
   // packet compare
   // ----------------------------------------------------------------
   arl_flag_matcher u_flag_matcher
   (
      .core_clk (core_clk),
      .reset    (reset),
      .pkt      (pkt),
      .cfg      (state.cfg),
      .match    (match)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_table_select;
      @(posedge core_clk) disable iff (reset)
      (data_wr && (state.indirect_ctrl[7:5] != 3'h2)) |=> $stable(state.cfg);
   endproperty
   a_table_select: assert property (p_table_select) // RULE_01
      else $error("rule bytes changed outside the acl table");

   property p_port_isolation;
      @(posedge core_clk) disable iff (reset)
      (data_wr && hit && (state.indirect_ctrl[3:0] == 4'h1)) |=>
         $stable(state.cfg.tcp_flag_select_mask[4:1]) &&
         $stable(state.cfg.ip_protocol_value[4:1]);
   endproperty
   a_port_isolation: assert property (p_port_isolation) // RULE_02
      else $error("port 1 write touched another port");

   property p_offset_select;
      @(posedge core_clk) disable iff (reset)
      (data_wr && hit && (state.indirect_offs == 8'h07)) |=>
         $stable(state.cfg.tcp_flag_select_mask);
   endproperty
   a_offset_select: assert property (p_offset_select) // RULE_03
      else $error("offset 7 write changed the mask");

   property p_data_read;
      @(posedge core_clk) disable iff (reset)
      (data_rd && hit && (state.indirect_offs == 8'h08)) |=>
         bus_rvalid && (bus_rdata == $past(state.cfg.tcp_flag_select_mask[idx]));
   endproperty
   a_data_read: assert property (p_data_read) // RULE_04
      else $error("indirect read returned wrong mask byte");

   property p_protocol_write;
      @(posedge core_clk) disable iff (reset)
      (data_wr && hit && (state.indirect_offs == 8'h07)) |=>
         (state.cfg.ip_protocol_value[$past(idx)] == $past(bus_req.wdata[7:1]));
   endproperty
   a_protocol_write: assert property (p_protocol_write) // RULE_05
      else $error("protocol value not stored from bits 7..1");

   property p_enable_write;
      @(posedge core_clk) disable iff (reset)
      (data_wr && hit && (state.indirect_offs == 8'h07)) |=>
         (state.cfg.flag_compare_enable[$past(idx)] == $past(bus_req.wdata[0]));
   endproperty
   a_enable_write: assert property (p_enable_write) // RULE_06
      else $error("flag compare enable not stored from bit 0");

   property p_mask_write;
      @(posedge core_clk) disable iff (reset)
      (data_wr && hit && (state.indirect_offs == 8'h08)) |=>
         (state.cfg.tcp_flag_select_mask[$past(idx)] == $past(bus_req.wdata)) ##1
         ($stable(state.cfg.tcp_flag_select_mask) || $past(data_wr));
   endproperty
   a_mask_write: assert property (p_mask_write) // RULE_07
      else $error("mask byte not stored or drifted");

   property p_reset_values;
      @(posedge core_clk)
      $fell(reset) |-> (state.cfg.ip_protocol_value == '0) &&
         (state.cfg.flag_compare_enable == '0) && (state.cfg.tcp_flag_select_mask == '0);
   endproperty
   a_reset_values: assert property (p_reset_values) // RULE_05
      else $error("rule bytes not zero after reset");

   property p_read_answer;
      @(posedge core_clk) disable iff (reset)
      bus_req.rd |=> bus_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) // RULE_04
      else $error("read strobe not answered next cycle");

   property p_refused_read;
      @(posedge core_clk) disable iff (reset)
      (data_rd && !hit) |=> (bus_rvalid && (bus_rdata == 8'h00));
   endproperty
   a_refused_read: assert property (p_refused_read) // RULE_01
      else $error("refused indirect read returned data");

endmodule : arl_rule_bank

// ===== hdl/arl_pkg.sv
// arl_pkg: constants and carrier types for the layer-4 rule match bytes.
// assumes one clock domain; every user writes arl_pkg::name.
package arl_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_INDIRECT_CTRL = 8'h6E;
   localparam logic [7:0] ADDR_INDIRECT_OFFS = 8'h6F;
   localparam logic [7:0] ADDR_INDIRECT_DATA = 8'hA0;

   // ----------------------------------------------------------------
   // indirect control fields
   // ----------------------------------------------------------------
   localparam int         TSEL_MSB   = 7;
   localparam int         TSEL_LSB   = 5;
   localparam int         PORT_MSB   = 3;
   localparam int         PORT_LSB   = 0;
   localparam logic [2:0] TSEL_ACL   = 3'h2;
   localparam logic [3:0] PORT_FIRST = 4'h1;
   localparam logic [3:0] PORT_LAST  = 4'h5;
   localparam int         NUM_PORTS  = 5;

   // ----------------------------------------------------------------
   // rule byte offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFFS_PROTOCOL = 8'h07;
   localparam logic [7:0] OFFS_MASK     = 8'h08;
   localparam logic [7:0] OFFS_EXPECT   = 8'h09;
   localparam int         PROTO_MSB     = 7;
   localparam int         PROTO_LSB     = 1;
   localparam int         FCE_BIT       = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] RST_PROTOCOL = 7'h00;
   localparam logic       RST_FCE      = 1'b0;
   localparam logic [7:0] RST_MASK     = 8'h00;
   localparam logic [7:0] RST_EXPECT   = 8'h00;
   localparam logic [7:0] RST_BYTE     = 8'h00;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } arl_bus_req_type;

   typedef struct packed {
      logic       valid;
      logic [3:0] port;
      logic [7:0] protocol;
      logic [7:0] tcp_flags;
   } arl_pkt_type;

   typedef struct packed {
      logic [NUM_PORTS-1:0][6:0] ip_protocol_value;
      logic [NUM_PORTS-1:0]      flag_compare_enable;
      logic [NUM_PORTS-1:0][7:0] tcp_flag_select_mask;
      logic [NUM_PORTS-1:0][7:0] acl_rule_byte_nine;
   } arl_rule_cfg_type;

   typedef struct packed {
      logic       valid;
      logic [3:0] port;
      logic       protocol_hit;
      logic       flag_hit;
   } arl_match_type;

   typedef struct packed {
      logic [7:0]       indirect_ctrl;
      logic [7:0]       indirect_offs;
      arl_rule_cfg_type cfg;
      logic [7:0]       rdata;
      logic             rvalid;
   } arl_state_type;

endpackage : arl_pkg

// ===== hdl/arl_flag_matcher.sv
// arl_flag_matcher: compares received packets against one port's rule bytes.
// assumes packet fields are synchronous to core_clk; result one cycle later.
`timescale 1ns/1ps

module arl_flag_matcher
(
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire arl_pkg::arl_pkt_type      pkt,
   input  wire arl_pkg::arl_rule_cfg_type cfg,
   output arl_pkg::arl_match_type         match
);

   arl_pkg::arl_match_type state;
   arl_pkg::arl_match_type next_state;
   logic [2:0]             idx;
   logic                   port_ok;

   assign idx     = 3'(pkt.port - arl_pkg::PORT_FIRST);
   assign port_ok = (pkt.port >= arl_pkg::PORT_FIRST) && (pkt.port <= arl_pkg::PORT_LAST);

   always_comb
   begin
      next_state       = '0;
      next_state.valid = pkt.valid && port_ok;
      next_state.port  = pkt.port;
      if (pkt.valid && port_ok)
      begin
         next_state.protocol_hit =
            (pkt.protocol == {1'b0, cfg.ip_protocol_value[idx]});
         // RULE_08 masked flag compare
         next_state.flag_hit = !cfg.flag_compare_enable[idx] ||
            (((pkt.tcp_flags ^ cfg.acl_rule_byte_nine[idx])
              & cfg.tcp_flag_select_mask[idx]) == 8'h00);
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         state <= '0;
      else
         state <= next_state;
   end

   assign match = state;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_masked_flags;
      @(posedge core_clk) disable iff (reset)
      (pkt.valid && port_ok && cfg.flag_compare_enable[idx]) |=>
         (match.flag_hit == (((($past(pkt.tcp_flags) ^ $past(cfg.acl_rule_byte_nine[idx]))
            & $past(cfg.tcp_flag_select_mask[idx]))) == 8'h00));
   endproperty
   a_masked_flags: assert property (p_masked_flags) // RULE_08
      else $error("flag hit does not follow masked compare");

   property p_flags_off;
      @(posedge core_clk) disable iff (reset)
      (pkt.valid && port_ok && !cfg.flag_compare_enable[idx]) |=> match.flag_hit;
   endproperty
   a_flags_off: assert property (p_flags_off) // RULE_06
      else $error("flag compare active while disabled");

endmodule : arl_flag_matcher

// ===== sim/test_arl_rule_bank.sv
// test_arl_rule_bank: self-checking bench for the rule match byte bank.
// assumes arl_pkg and arl_rule_bank are compiled first; one 50 MHz clock.
`timescale 1ns/1ps

module test_arl_rule_bank;

   // ----------------------------------------------------------------
   // signals and reference model
   // ----------------------------------------------------------------
   logic                      core_clk;
   logic                      reset;
   arl_pkg::arl_bus_req_type  bus_req;
   logic [7:0]                bus_rdata;
   logic                      bus_rvalid;
   arl_pkg::arl_pkt_type      pkt;
   arl_pkg::arl_rule_cfg_type rule_cfg;
   arl_pkg::arl_match_type    match;
   logic [31:0]               seed;
   logic [7:0]                rdq[$];
   logic [7:0]                mq[$];
   logic [7:0]                b7[1:5];
   logic [7:0]                b8[1:5];
   logic [7:0]                b9[1:5];
   logic [7:0]                v;
   logic [7:0]                pr;
   logic [7:0]                fl;
   int                        p;
   int                        o;
   int                        mismatches;
   int                        cmp_count;

   arl_rule_bank u_dut
   (
      .core_clk   (core_clk),
      .reset      (reset),
      .bus_req    (bus_req),
      .bus_rdata  (bus_rdata),
      .bus_rvalid (bus_rvalid),
      .pkt        (pkt),
      .rule_cfg   (rule_cfg),
      .match      (match)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [7:0] mbyte(input int pp, input int oo);
      return (oo == 7) ? b7[pp] : (oo == 8) ? b8[pp] : b9[pp];
   endfunction : mbyte

   task bus_op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      bus_req <= {a, d, w, r};
   endtask : bus_op

   task bus_idle;
      @(negedge core_clk);
      bus_req <= '0;
   endtask : bus_idle

   task sel(input logic [2:0] ts, input logic [3:0] pp, input logic [7:0] oo);
      bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_CTRL, {ts, 1'b0, pp});
      bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_OFFS, oo);
   endtask : sel

   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      bus_op(1'b0, 1'b1, a, 8'h00);
      rdq.push_back(e);
   endtask : rd_chk

   // reads every rule byte of every port and the level outputs
   task rd_all;
      for (int pp = 1; pp <= 5; pp++)
      begin
         for (int oo = 7; oo <= 9; oo++)
         begin
            sel(arl_pkg::TSEL_ACL, pp[3:0], oo[7:0]);
            rd_chk(arl_pkg::ADDR_INDIRECT_DATA, mbyte(pp, oo));
         end
      end
      bus_idle;
      repeat (2) @(negedge core_clk);
      for (int pp = 1; pp <= 5; pp++)
      begin
         check("cfg7", {rule_cfg.ip_protocol_value[pp-1],
                        rule_cfg.flag_compare_enable[pp-1]}, b7[pp]);
         check("cfg8", rule_cfg.tcp_flag_select_mask[pp-1], b8[pp]);
         check("cfg9", rule_cfg.acl_rule_byte_nine[pp-1], b9[pp]);
      end
   endtask : rd_all

   task pkt_send(input int pp, input logic [7:0] ppr, input logic [7:0] pfl);
      logic ph;
      logic fh;
      @(negedge core_clk);
      pkt <= {1'b1, pp[3:0], ppr, pfl};
      if (pp >= 1 && pp <= 5)
      begin
         ph = (ppr === {1'b0, b7[pp][7:1]});
         fh = !b7[pp][0] || ((pfl & b8[pp]) === (b9[pp] & b8[pp]));
         mq.push_back({1'b0, pp[3:0], 1'b0, ph, fh});
      end
   endtask : pkt_send

   task tally_and_finish;
      if (rdq.size() != 0 || mq.size() != 0)
         mismatches++;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // output monitor
   // ----------------------------------------------------------------
   always @(negedge core_clk)
   begin
      if (bus_rvalid === 1'b1)
      begin
         if (rdq.size() == 0)
            check("rvalid_extra", 8'h01, 8'h00);
         else
            check("rdata", bus_rdata, rdq.pop_front());
      end
      else
         check("rdata_idle", bus_rdata, 8'h00);
      if (match.valid === 1'b1)
      begin
         if (mq.size() == 0)
            check("match_extra", 8'h01, 8'h00);
         else
            check("match", {1'b0, match.port, 1'b0, match.protocol_hit,
                            match.flag_hit}, mq.pop_front());
      end
   end

   initial
   begin
      #100000;
      mismatches++;
      tally_and_finish;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      bus_req = '0;
      pkt = '0;
      seed = 32'h00000039;
      mismatches = 0;
      cmp_count = 0;
      for (p = 1; p <= 5; p++)
      begin
         b7[p] = 8'h00;
         b8[p] = 8'h00;
         b9[p] = 8'h00;
      end
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      rd_all;
      for (p = 1; p <= 5; p++)
      begin
         for (o = 7; o <= 9; o++)
         begin
            v = 8'(xs() >> 3);
            if (o == 7)
               v[0] = p[0];
            sel(arl_pkg::TSEL_ACL, p[3:0], o[7:0]);
            bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_DATA, v);
            if (o == 7) b7[p] = v;
            else if (o == 8) b8[p] = v;
            else b9[p] = v;
            rd_chk(arl_pkg::ADDR_INDIRECT_DATA, v);
         end
      end
      rd_all;
      rd_chk(arl_pkg::ADDR_INDIRECT_CTRL, {arl_pkg::TSEL_ACL, 1'b0, 4'h5});
      rd_chk(arl_pkg::ADDR_INDIRECT_OFFS, 8'h09);
      sel(3'h1, 4'h1, 8'h07);
      bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_DATA, 8'hA5);
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h00);
      sel(3'h6, 4'h3, 8'h08);
      bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_DATA, 8'h5A);
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h00);
      sel(arl_pkg::TSEL_ACL, 4'h0, 8'h07);
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h00);
      sel(arl_pkg::TSEL_ACL, 4'h6, 8'h08);
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h00);
      sel(arl_pkg::TSEL_ACL, 4'h2, 8'h06);
      bus_op(1'b1, 1'b0, arl_pkg::ADDR_INDIRECT_DATA, 8'hFF);
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h00);
      rd_chk(8'h55, 8'h00);
      // write and read in one cycle
      sel(arl_pkg::TSEL_ACL, 4'h4, 8'h08);
      bus_op(1'b1, 1'b1, arl_pkg::ADDR_INDIRECT_DATA, 8'h3C);
      rdq.push_back(b8[4]);
      b8[4] = 8'h3C;
      rd_chk(arl_pkg::ADDR_INDIRECT_DATA, 8'h3C);
      rd_all;
      for (int i = 0; i < 80; i++)
      begin
         p = xs() % 7;
         v = 8'(xs() >> 5);
         pr = (p >= 1 && p <= 5 && v[0]) ? {1'b0, b7[p][7:1]} : v;
         fl = 8'(xs() >> 9);
         if (p >= 1 && p <= 5 && v[1])
            fl = (b9[p] & b8[p]) | (fl & ~b8[p]);
         pkt_send(p, pr, fl);
      end
      @(negedge core_clk);
      pkt <= '0;
      repeat (4) @(negedge core_clk);
      reset = 1'b1;
      for (p = 1; p <= 5; p++)
      begin
         b7[p] = 8'h00;
         b8[p] = 8'h00;
         b9[p] = 8'h00;
      end
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      rd_all;
      tally_and_finish;
   end

endmodule : test_arl_rule_bank
